// file: logic/roc_cond.sv
`timescale 1ns/1ns
// What this block does
// - In normal mode each channel output follows the live bus bit of that channel.
// - In simulation mode the bus bit is ignored and the configured simulation value is used instead.
// - On watchdog expiry or an invalid-data status the configured error strategy governs the output.
// - Line faults never start the substitute strategy; there is no line fault input at all.
// - The current-value strategy keeps passing the live or simulated bit unchanged during an error.
// - The substitute strategy drives the configured substitute bit while the error lasts.
// - The last-valid strategy holds the final value that was valid before the error began.
// - With inversion enabled the channel bit is complemented.
// - A 0-to-1 change is delayed by the ON delay in ms, removing shorter high pulses.
// - A 1-to-0 change is delayed by the OFF delay in ms, stretching short high pulses.
// - The substitute bit is one bit and is always reported with invalid status.
// - The simulation bit carries an OK or invalid status, and invalid forces the substitute strategy.
// - Every channel is active exactly when the module-wide active bit is set.
// - If exchanges with the com unit stop, the safe state is entered after 0.5 s.
// - Output status is exchanged with the com unit every 6.5 ms regardless of other timing.
module roc_cond
  import roc_pkg::*;
#(
  parameter int NCH = ROC_NCH,
  parameter int TICK_CYC = ROC_TICK_CYC,
  parameter int WDOG_CYC = ROC_WDOG_CYC,
  parameter int XCHG_CYC = ROC_XCHG_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [ROC_AW-1:0] reg_addr,
  input wire logic [ROC_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ROC_DW-1:0] reg_rdata,
  input wire logic bus_update,
  input wire logic [NCH-1:0] bus_bit,
  input wire logic [NCH-1:0] bus_invalid,
  output logic [NCH-1:0] relay_out,
  output logic [NCH-1:0] out_invalid,
  output logic [NCH-1:0] xchg_status,
  output logic xchg_strobe,
  output logic irq
);
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int WW = $clog2(WDOG_CYC + 1);
  localparam int XW = $clog2(XCHG_CYC + 1);

  function automatic logic hit(input logic [ROC_AW-1:0] a, input logic [7:0] off);
    hit = a == off[ROC_AW-1:0];
  endfunction

  logic active;
  logic [ROC_CFG_W-1:0] cfg [NCH];
  logic [ROC_DLYW-1:0] on_ms [NCH];
  logic [ROC_DLYW-1:0] off_ms [NCH];
  logic [ROC_IRQ_W-1:0] irq_stat;
  logic [ROC_IRQ_W-1:0] irq_mask;
  logic [NCH-1:0] last_valid;
  logic [NCH-1:0] err_q;
  logic wdog_q;
  logic [TW-1:0] tick_cnt;
  logic ms_tick;
  logic [WW-1:0] wdog_cnt;
  logic [XW-1:0] xchg_cnt;
  logic [NCH-1:0] filt;

  wire wr_ctrl = reg_wr && hit(reg_addr, ROC_REG_CTRL);
  wire wr_cfg0 = reg_wr && hit(reg_addr, ROC_REG_CH0_CFG);
  wire wr_cfg1 = reg_wr && hit(reg_addr, ROC_REG_CH1_CFG);
  wire wr_on0 = reg_wr && hit(reg_addr, ROC_REG_ON0);
  wire wr_off0 = reg_wr && hit(reg_addr, ROC_REG_OFF0);
  wire wr_on1 = reg_wr && hit(reg_addr, ROC_REG_ON1);
  wire wr_off1 = reg_wr && hit(reg_addr, ROC_REG_OFF1);
  wire wr_istat = reg_wr && hit(reg_addr, ROC_REG_IRQ_STAT);
  wire wr_imask = reg_wr && hit(reg_addr, ROC_REG_IRQ_MASK);

  // watchdog runs while no exchange arrives; expiry is sticky until the next exchange
  wire wdog_exp = wdog_cnt == WW'(WDOG_CYC);
  wire [WW-1:0] next_wdog_cnt = bus_update ? '0 : (wdog_exp ? wdog_cnt : wdog_cnt + 1'b1);
  wire tick_end = tick_cnt == TW'(TICK_CYC - 1);
  wire xchg_end = xchg_cnt == XW'(XCHG_CYC - 1);

  logic [NCH-1:0] src_bit;
  logic [NCH-1:0] src_bad;
  logic [NCH-1:0] ch_err;
  logic [NCH-1:0] use_subst;
  logic [NCH-1:0] chosen;
  logic [NCH-1:0] shaped;
  logic [NCH-1:0] next_relay;
  logic [NCH-1:0] next_bad;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire sim = cfg[c][ROC_CFG_SIM];
    wire [1:0] strat = cfg[c][ROC_CFG_STRAT +: 2];
    assign src_bit[c] = sim ? cfg[c][ROC_CFG_SIMVAL] : bus_bit[c];
    assign src_bad[c] = sim ? cfg[c][ROC_CFG_SIMBAD] : bus_invalid[c];
    assign ch_err[c] = wdog_exp || src_bad[c];
    // invalid simulation status selects the substitute regardless of strategy
    assign use_subst[c] = ch_err[c] && (strat == ROC_STRAT_SUBST || (sim && cfg[c][ROC_CFG_SIMBAD]));
    assign chosen[c] = use_subst[c] ? cfg[c][ROC_CFG_SUBST]
      : (ch_err[c] && strat == ROC_STRAT_LAST) ? last_valid[c]
      : src_bit[c];
    assign shaped[c] = chosen[c] ^ cfg[c][ROC_CFG_INV];
    assign next_relay[c] = active && filt[c];
    // substitute output always reports invalid; current-value codes 0 and 3 pass on an
    // invalid source status, while the last-valid strategy reports its held bit as valid
    assign next_bad[c] = !active || use_subst[c] || (src_bad[c] && strat != ROC_STRAT_LAST);

    roc_delay #(
      .DLYW(ROC_DLYW)
    ) u_delay (
      .core_clk(core_clk),
      .resetn(resetn),
      .ms_tick(ms_tick),
      .din(shaped[c]),
      .on_ms(on_ms[c]),
      .off_ms(off_ms[c]),
      .dout(filt[c])
    );
  end

  wire [ROC_IRQ_W-1:0] irq_evt = {ch_err & ~err_q, wdog_exp & ~wdog_q};
  wire [ROC_IRQ_W-1:0] next_irq_stat = (irq_stat & ~(wr_istat ? reg_wdata[ROC_IRQ_W-1:0] : '0)) | irq_evt;

  wire [ROC_DW-1:0] status_word = ROC_DW'({out_invalid, wdog_exp, ch_err, relay_out});
  wire [ROC_DW-1:0] rd_mux =
    hit(reg_addr, ROC_REG_CTRL) ? ROC_DW'(active) :
    hit(reg_addr, ROC_REG_CH0_CFG) ? ROC_DW'(cfg[0]) :
    hit(reg_addr, ROC_REG_CH1_CFG) ? ROC_DW'(cfg[1]) :
    hit(reg_addr, ROC_REG_ON0) ? ROC_DW'(on_ms[0]) :
    hit(reg_addr, ROC_REG_OFF0) ? ROC_DW'(off_ms[0]) :
    hit(reg_addr, ROC_REG_ON1) ? ROC_DW'(on_ms[1]) :
    hit(reg_addr, ROC_REG_OFF1) ? ROC_DW'(off_ms[1]) :
    hit(reg_addr, ROC_REG_STATUS) ? status_word :
    hit(reg_addr, ROC_REG_IRQ_STAT) ? ROC_DW'(irq_stat) :
    hit(reg_addr, ROC_REG_IRQ_MASK) ? ROC_DW'(irq_mask) : '0;

  // module-wide active bit; channels follow it and have no enable of their own
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      active <= ROC_CTRL_RST;
    end else if (wr_ctrl) begin
      active <= reg_wdata[ROC_CTRL_ACTIVE];
    end
  end

  // per-channel settings, one independent copy for each channel
  for (genvar c = 0; c < NCH; c++) begin : g_regs
    wire wr_cfg = c == 0 ? wr_cfg0 : wr_cfg1;
    wire wr_on = c == 0 ? wr_on0 : wr_on1;
    wire wr_off = c == 0 ? wr_off0 : wr_off1;

    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        cfg[c] <= ROC_CFG_RST;
      end else if (wr_cfg) begin
        cfg[c] <= reg_wdata[ROC_CFG_W-1:0];
      end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        on_ms[c] <= ROC_DLY_RST;
      end else if (wr_on) begin
        on_ms[c] <= reg_wdata[ROC_DLYW-1:0];
      end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        off_ms[c] <= ROC_DLY_RST;
      end else if (wr_off) begin
        off_ms[c] <= reg_wdata[ROC_DLYW-1:0];
      end
    end
  end

  // interrupt enables, same layout as the status bits
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask <= ROC_IRQ_RST;
    end else if (wr_imask) begin
      irq_mask <= reg_wdata[ROC_IRQ_W-1:0];
    end
  end

  // free-running divider from the module clock down to a 1 ms tick
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_end ? '0 : tick_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= tick_end;
    end
  end

  // watchdog counter, cleared by every exchange from the com unit
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wdog_cnt <= '0;
    end else begin
      wdog_cnt <= next_wdog_cnt;
    end
  end

  // exchange period counter and its one-cycle strobe
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      xchg_cnt <= '0;
    end else begin
      xchg_cnt <= xchg_end ? '0 : xchg_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      xchg_strobe <= 1'b0;
    end else begin
      xchg_strobe <= xchg_end;
    end
  end

  // snapshot of the outputs handed to the com unit on each strobe
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      xchg_status <= '0;
    end else if (xchg_end) begin
      xchg_status <= relay_out;
    end
  end

  // last valid source bit, frozen while the channel is in error
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      last_valid <= '0;
    end else begin
      last_valid <= (last_valid & ch_err) | (src_bit & ~ch_err);
    end
  end

  // previous error levels, used to find the onset of each error
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      err_q <= '0;
    end else begin
      err_q <= ch_err;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wdog_q <= 1'b0;
    end else begin
      wdog_q <= wdog_exp;
    end
  end

  // output stage: relay drive and invalid status
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      relay_out <= '0;
    end else begin
      relay_out <= next_relay;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      out_invalid <= '0;
    end else begin
      out_invalid <= next_bad;
    end
  end

  // sticky interrupt status; an event in the cycle of a clear keeps its bit set
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= ROC_IRQ_RST;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_stat & irq_mask);
    end
  end

  // read data stands for the one cycle after the strobe and is zero otherwise
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end
endmodule

// file: logic/roc_pkg.sv
package roc_pkg;
  localparam int ROC_CLK_HZ = 100_000_000;
  localparam int ROC_MS_PER_S = 1000;
  localparam int ROC_US_PER_MS = 1000;
  // timing figures as printed
  localparam int ROC_TICK_MS = 1;
  localparam int ROC_WDOG_MS = 500;
  localparam int ROC_XCHG_US = 6500;
  localparam int ROC_TICK_CYC = ROC_CLK_HZ / ROC_MS_PER_S * ROC_TICK_MS;
  localparam int ROC_WDOG_CYC = ROC_CLK_HZ / ROC_MS_PER_S * ROC_WDOG_MS;
  localparam int ROC_XCHG_CYC = ROC_CLK_HZ / (ROC_MS_PER_S * ROC_US_PER_MS) * ROC_XCHG_US;

  localparam int ROC_NCH = 2;
  localparam int ROC_AW = 8;
  localparam int ROC_DW = 32;
  localparam int ROC_DLYW = 16;

  // register byte offsets
  localparam logic [7:0] ROC_REG_CTRL = 8'h00;
  localparam logic [7:0] ROC_REG_CH0_CFG = 8'h04;
  localparam logic [7:0] ROC_REG_CH1_CFG = 8'h08;
  localparam logic [7:0] ROC_REG_ON0 = 8'h0c;
  localparam logic [7:0] ROC_REG_OFF0 = 8'h10;
  localparam logic [7:0] ROC_REG_ON1 = 8'h14;
  localparam logic [7:0] ROC_REG_OFF1 = 8'h18;
  localparam logic [7:0] ROC_REG_STATUS = 8'h1c;
  localparam logic [7:0] ROC_REG_IRQ_STAT = 8'h20;
  localparam logic [7:0] ROC_REG_IRQ_MASK = 8'h24;

  // ctrl fields
  localparam int ROC_CTRL_ACTIVE = 0;
  localparam logic [0:0] ROC_CTRL_RST = 1'h0;
  // channel config fields
  localparam int ROC_CFG_SIM = 0;
  localparam int ROC_CFG_STRAT = 1;
  localparam int ROC_CFG_INV = 3;
  localparam int ROC_CFG_SUBST = 4;
  localparam int ROC_CFG_SIMVAL = 5;
  localparam int ROC_CFG_SIMBAD = 6;
  localparam int ROC_CFG_W = 7;
  localparam logic [6:0] ROC_CFG_RST = 7'h00;
  localparam logic [15:0] ROC_DLY_RST = 16'h0000;
  // irq status fields
  localparam int ROC_IRQ_WDOG = 0;
  localparam int ROC_IRQ_ERR0 = 1;
  localparam int ROC_IRQ_W = 3;
  localparam logic [2:0] ROC_IRQ_RST = 3'h0;
  // status fields: [1:0] outputs, [3:2] error, [4] watchdog expired, [6:5] invalid
  localparam int ROC_ST_OUT = 0;
  localparam int ROC_ST_ERR = 2;
  localparam int ROC_ST_WDOG = 4;
  localparam int ROC_ST_BAD = 5;

  typedef enum logic [1:0] {
    ROC_STRAT_CURRENT = 2'h0,
    ROC_STRAT_SUBST = 2'h1,
    ROC_STRAT_LAST = 2'h2
  } roc_strat_t;
endpackage

// file: logic/roc_delay.sv
`timescale 1ns/1ns
module roc_delay
  import roc_pkg::*;
#(
  parameter int DLYW = ROC_DLYW
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ms_tick,
  input wire logic din,
  input wire logic [DLYW-1:0] on_ms,
  input wire logic [DLYW-1:0] off_ms,
  output logic dout
);
  logic [DLYW-1:0] cnt;
  wire pending = din != dout;
  wire [DLYW-1:0] limit = din ? on_ms : off_ms; // rising uses on delay falling off delay
  wire done = cnt >= limit;
  wire [DLYW-1:0] next_cnt = !pending || done ? '0 : (ms_tick ? cnt + 1'b1 : cnt);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      dout <= 1'b0;
    end else begin
      cnt <= next_cnt;
      if (pending && done) begin
        dout <= din; // a pulse shorter than the delay never gets here
      end
    end
  end
endmodule

// file: testbench/roc_checker.sv
`timescale 1ns/1ns
module roc_checker #(
  parameter int XCHG_CYC = 50
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [1:0] relay_out,
  input wire logic [1:0] xchg_status,
  input wire logic xchg_strobe,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_quiet;
    !xchg_strobe [*8];
  endsequence
  sequence s_boot;
    (relay_out == 2'h0 && !irq && !xchg_strobe) [*2];
  endsequence
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
  endproperty
  property p_rd_unmapped;
    $past(reg_rd) && $past(reg_addr) > 8'h27 |-> reg_rdata == 32'h0000_0000;
  endproperty
  property p_boot;
    $past(!resetn) |-> s_boot;
  endproperty
  property p_xchg_pulse;
    xchg_strobe |=> s_quiet;
  endproperty
  property p_xchg_period;
    xchg_strobe |-> ##XCHG_CYC xchg_strobe;
  endproperty
  property p_xchg_hold;
    !xchg_strobe |-> $stable(xchg_status);
  endproperty
  property p_xchg_snap;
    xchg_strobe && $stable(relay_out) |-> xchg_status == relay_out;
  endproperty
  property p_irq_fall;
    $fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  a_boot: assert property (p_boot) else $error("outputs active after reset");
  a_xchg_pulse: assert property (p_xchg_pulse) else $error("exchange strobe too long");
  a_xchg_period: assert property (p_xchg_period) else $error("exchange period wrong");
  a_xchg_hold: assert property (p_xchg_hold) else $error("status moved between exchanges");
  a_xchg_snap: assert property (p_xchg_snap) else $error("status snapshot wrong");
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
endmodule
bind roc_cond roc_checker #(.XCHG_CYC(XCHG_CYC)) i_roc_checker(.core_clk, .resetn, .reg_addr, .reg_wr,
  .reg_rd, .reg_rdata, .relay_out, .xchg_status, .xchg_strobe, .irq);

// file: testbench/roc_com_model.sv
`timescale 1ns/1ns
module roc_com_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic halt,
  input wire logic [7:0] gap,
  input wire logic [1:0] cmd_bit,
  input wire logic [1:0] cmd_bad,
  output logic bus_update,
  output logic [1:0] bus_bit,
  output logic [1:0] bus_invalid
);
  logic [7:0] cnt;
  wire go = !halt && cnt >= gap;
  // exchange every gap+1 cycles, data refreshed only with it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 8'h00;
      bus_update <= 1'b0;
      bus_bit <= 2'h0;
      bus_invalid <= 2'h0;
    end else begin
      cnt <= (cnt >= gap) ? 8'h00 : cnt + 8'h01;
      bus_update <= go;
      if (go) begin
        bus_bit <= cmd_bit;
        bus_invalid <= cmd_bad;
      end
    end
  end
endmodule

// file: testbench/relay_output_channel_conditioner_test.sv
`timescale 1ns/1ns
module relay_output_channel_conditioner_test;
  import roc_pkg::*;
  logic core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, halt = 0, bus_update, xchg_strobe, irq;
  logic [7:0] reg_addr = 0, gap = 8'h01;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [1:0] cmd_bit = 0, cmd_bad = 0, relay_out, out_invalid, xchg_status, bus_bit, bus_invalid;
  logic [6:0] cfg [2];
  logic [2:0] e;
  logic lv [2];
  logic [7:0] tbl [6] = '{ROC_REG_CTRL, ROC_REG_CH0_CFG, ROC_REG_ON0, ROC_REG_OFF1, ROC_REG_IRQ_MASK, 8'h40};
  int failures = 0, samples_checked = 0, cyc = 0;
  initial forever #5 core_clk = ~core_clk;
  roc_com_model i_roc_com_model(.core_clk, .resetn, .halt, .gap, .cmd_bit, .cmd_bad, .bus_update, .bus_bit,
    .bus_invalid);
  roc_cond #(.TICK_CYC(10), .WDOG_CYC(200), .XCHG_CYC(50)) i_roc_cond(.core_clk, .resetn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bus_update, .bus_bit, .bus_invalid, .relay_out,
    .out_invalid, .xchg_status, .xchg_strobe, .irq);
  task automatic summarize;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      summarize();
    end
  end
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    step(1);
    reg_wr <= 0;
    step(1);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1;
    step(1);
    reg_rd <= 0;
    @(negedge core_clk) chk(reg_rdata, exp);
    step(1);
  endtask
  task automatic look(int n, logic [4:0] exp);
    step(n);
    @(negedge core_clk) chk({irq, out_invalid, relay_out}, exp);
    step(1);
  endtask
  // returns {next last valid, invalid, output}
  function automatic logic [2:0] f(logic [6:0] c, logic b, logic bad, logic l);
    logic er, s, sub;
    er = c[ROC_CFG_SIM] ? c[ROC_CFG_SIMBAD] : bad;
    s = c[ROC_CFG_SIM] ? c[ROC_CFG_SIMVAL] : b;
    sub = c[2:1] == ROC_STRAT_SUBST || (c[ROC_CFG_SIM] && c[ROC_CFG_SIMBAD]);
    if (!er) return {s, 1'b0, s ^ c[ROC_CFG_INV]};
    if (sub) return {l, 1'b1, c[ROC_CFG_SUBST] ^ c[ROC_CFG_INV]};
    return {l, c[2:1] != ROC_STRAT_LAST, (c[2:1] == ROC_STRAT_LAST ? l : s) ^ c[ROC_CFG_INV]};
  endfunction
  initial begin
    void'($urandom(14));
    step(16);
    resetn <= 1;
    step(1);
    for (int i = 0; i < 6; i++) rd(tbl[i], 0);
    look(8, 5'b0_11_00);
    $display("reset test done");
    wr(ROC_REG_CTRL, 1);
    cfg = '{7'h00, 7'h00};
    lv = '{1'b0, 1'b0};
    for (int i = 0; i < 40; i++) begin
      if (i % 2) begin
        cmd_bit <= 2'($urandom);
        cmd_bad <= 2'($urandom);
      end else for (int c = 0; c < 2; c++) begin
        cfg[c] = 7'($urandom);
        wr(c ? ROC_REG_CH1_CFG : ROC_REG_CH0_CFG, 32'(cfg[c]));
      end
      step(12);
      @(negedge core_clk);
      for (int c = 0; c < 2; c++) begin
        e = f(cfg[c], cmd_bit[c], cmd_bad[c], lv[c]);
        chk({out_invalid[c], relay_out[c]}, e[1:0]);
        lv[c] = e[2];
      end
      step(1);
    end
    $display("mode and strategy test done");
    cmd_bit <= 0;
    cmd_bad <= 0;
    wr(ROC_REG_CH0_CFG, 0);
    wr(ROC_REG_CH1_CFG, 0);
    wr(ROC_REG_ON0, 3);
    wr(ROC_REG_OFF0, 3);
    step(60);
    cmd_bit <= 2'h3;
    look(8, 5'b0_00_10);
    cmd_bit <= 0;
    step(5);
    for (int i = 0; i < 40; i++) look(0, 5'b0_00_00);
    cmd_bit <= 2'h3;
    look(15, 5'b0_00_10);
    look(35, 5'b0_00_11);
    cmd_bit <= 0;
    step(8);
    cmd_bit <= 2'h3;
    step(5);
    for (int i = 0; i < 40; i++) look(0, 5'b0_00_11);
    cmd_bit <= 0;
    look(15, 5'b0_00_01);
    look(35, 5'b0_00_00);
    wr(ROC_REG_CH0_CFG, 8);
    look(15, 5'b0_00_00);
    look(35, 5'b0_00_01);
    $display("delay test done");
    wr(ROC_REG_CH0_CFG, 32'h0000_0012);
    wr(ROC_REG_IRQ_MASK, 1);
    halt <= 1;
    look(150, 5'b0_00_00);
    look(120, 5'b1_01_01);
    rd(ROC_REG_IRQ_STAT, 32'h0000_0007);
    wr(ROC_REG_IRQ_MASK, 0);
    look(0, 5'b0_01_01);
    wr(ROC_REG_IRQ_MASK, 1);
    look(0, 5'b1_01_01);
    halt <= 0;
    step(5);
    wr(ROC_REG_IRQ_STAT, 1);
    look(0, 5'b0_00_01);
    $display("watchdog test done");
    summarize();
  end
endmodule
